// ==== core/pop_top.v ====
// Notes on behaviour
// - polarity 0: duty sets high time
// - polarity 1: waveform inverted, duty sets low
// - low registers channels 7-0, high 15-8
// - direction 0 input; 1 with enable 0 port
// - direction 1 enable 1 drives modulated waveform
// - prescale bits 2,1 with enable, source pick clock
// - off, system clock, or divided by 2-16
// - upper duty nibble sets basic pulse duty
// - lower nibble sets number of extra pulses
`include "pop_map.vh"
module pop_top #(
    parameter NCH = 16
) (
    // clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // register port
    input wire [`POP_ADDR_W-1:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // duty values from the data registers, channel n at [8n+7:8n]
    input wire [8*NCH-1:0] duty_i,
    // port direction and output latch, channel n at bit n
    input wire [NCH-1:0] port_dir_i,
    input wire [NCH-1:0] port_latch_i,
    // pins
    output wire [NCH-1:0] modulated_outputs_o,
    output wire [NCH-1:0] modulated_outputs_oe_o,
    // other timer clock selects
    output reg other_timer_clk_sel_a_o,
    output reg other_timer_clk_sel_b_o,
    output reg other_timer_clk_sel_c_o,
    // counter state
    output reg [7:0] count_o
);
    // software-visible registers
    reg [7:0] polarity_bits_low_r;
    reg [7:0] polarity_bits_high_r;
    reg [7:0] enable_bits_low_r;
    reg [7:0] enable_bits_high_r;
    reg [7:0] pcs_r;
    reg counter_clock_enable_r;
    reg counter_clock_source_r;
    // their next values, decoded from the write strobe
    reg [7:0] polarity_bits_low_nxt;
    reg [7:0] polarity_bits_high_nxt;
    reg [7:0] enable_bits_low_nxt;
    reg [7:0] enable_bits_high_nxt;
    reg [7:0] pcs_nxt;
    reg counter_clock_enable_nxt;
    reg counter_clock_source_nxt;
    reg [7:0] rdata_nxt;
    // prescaler and counter state
    reg [3:0] div_r;
    reg [7:0] cnt_r;
    reg tick_r;
    reg [3:0] div_nxt;
    reg [7:0] cnt_nxt;
    reg tick_nxt;
    wire prescale_select_hi = pcs_r[`POP_PCS_CKB];
    wire prescale_select_lo = pcs_r[`POP_PCS_CKA];

    // write decode; bit 3 of clock select is read-only zero
    always @* begin
        polarity_bits_low_nxt = polarity_bits_low_r;
        polarity_bits_high_nxt = polarity_bits_high_r;
        enable_bits_low_nxt = enable_bits_low_r;
        enable_bits_high_nxt = enable_bits_high_r;
        pcs_nxt = pcs_r;
        counter_clock_enable_nxt = counter_clock_enable_r;
        counter_clock_source_nxt = counter_clock_source_r;
        if (wr_i) begin
            case (addr_i)
                `POP_A_POL_LO: polarity_bits_low_nxt = wdata_i;
                `POP_A_POL_HI: polarity_bits_high_nxt = wdata_i;
                `POP_A_OE_LO: enable_bits_low_nxt = wdata_i;
                `POP_A_OE_HI: enable_bits_high_nxt = wdata_i;
                `POP_A_PCS: begin
                    // reserved bits 7,6 are kept as written; software owns them
                    pcs_nxt = wdata_i;
                    pcs_nxt[`POP_PCS_RSVD3] = 1'b0;
                end
                `POP_A_CCTL: begin
                    counter_clock_enable_nxt = wdata_i[`POP_CC_EN];
                    counter_clock_source_nxt = wdata_i[`POP_CC_SRC];
                end
                default: ;
            endcase
        end
    end

    // register file; unmapped indices leave every register as it was
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            polarity_bits_low_r <= `POP_RST_8;
            polarity_bits_high_r <= `POP_RST_8;
            enable_bits_low_r <= `POP_RST_8;
            enable_bits_high_r <= `POP_RST_8;
            pcs_r <= `POP_RST_8;
            counter_clock_enable_r <= 1'b0;
            counter_clock_source_r <= 1'b0;
        end else begin
            polarity_bits_low_r <= polarity_bits_low_nxt;
            polarity_bits_high_r <= polarity_bits_high_nxt;
            enable_bits_low_r <= enable_bits_low_nxt;
            enable_bits_high_r <= enable_bits_high_nxt;
            pcs_r <= pcs_nxt;
            counter_clock_enable_r <= counter_clock_enable_nxt;
            counter_clock_source_r <= counter_clock_source_nxt;
        end
    end

    // read mux; idle cycles and unmapped indices read zero
    always @* begin
        rdata_nxt = `POP_RST_8;
        if (rd_i) begin
            case (addr_i)
                `POP_A_POL_LO: rdata_nxt = polarity_bits_low_r;
                `POP_A_POL_HI: rdata_nxt = polarity_bits_high_r;
                `POP_A_OE_LO: rdata_nxt = enable_bits_low_r;
                `POP_A_OE_HI: rdata_nxt = enable_bits_high_r;
                `POP_A_PCS: rdata_nxt = pcs_r;
                `POP_A_CCTL: rdata_nxt = {6'h00, counter_clock_enable_r, counter_clock_source_r};
                default: rdata_nxt = `POP_RST_8;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= `POP_RST_8;
        end else begin
            rdata_o <= rdata_nxt;
        end
    end

    // other timer selects just pass through registered, no local effect
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            other_timer_clk_sel_a_o <= 1'b0;
            other_timer_clk_sel_b_o <= 1'b0;
            other_timer_clk_sel_c_o <= 1'b0;
        end else begin
            other_timer_clk_sel_a_o <= pcs_r[`POP_PCS_XA];
            other_timer_clk_sel_b_o <= pcs_r[`POP_PCS_XB];
            other_timer_clk_sel_c_o <= pcs_r[`POP_PCS_XC];
        end
    end

    // prescaler: a tick enable rather than a derived clock keeps one domain
    always @* begin
        tick_nxt = 1'b0;
        if (counter_clock_enable_r) begin
            if (!counter_clock_source_r) begin
                tick_nxt = 1'b1;
            end else begin
                case ({prescale_select_hi, prescale_select_lo})
                    `POP_PS_DIV2: tick_nxt = ((div_r & `POP_PS_M2) == `POP_PS_M2);
                    `POP_PS_DIV4: tick_nxt = ((div_r & `POP_PS_M4) == `POP_PS_M4);
                    `POP_PS_DIV8: tick_nxt = ((div_r & `POP_PS_M8) == `POP_PS_M8);
                    default: tick_nxt = ((div_r & `POP_PS_M16) == `POP_PS_M16);
                endcase
            end
        end
    end

    // divider runs only while enabled; all masks need bit 0, so divided ticks never abut
    always @* begin
        div_nxt = div_r;
        cnt_nxt = cnt_r;
        if (counter_clock_enable_r) begin
            div_nxt = div_r + `POP_DIV_STEP;
        end
        if (tick_nxt) begin
            cnt_nxt = cnt_r + `POP_CNT_STEP;
        end
    end

    // count_o trails the counter by one cycle, straight from a flop
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_r <= `POP_RST_DIV;
            cnt_r <= `POP_RST_8;
            tick_r <= 1'b0;
            count_o <= `POP_RST_8;
        end else begin
            tick_r <= tick_nxt;
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
            count_o <= cnt_r;
        end
    end

    // register pairs joined so channel n reads bit n
    wire [NCH-1:0] pol_all = {polarity_bits_high_r, polarity_bits_low_r};
    wire [NCH-1:0] oe_all = {enable_bits_high_r, enable_bits_low_r};

    // one channel stage per output pin
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            pop_chan u_ch (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .tick_i(tick_r),
                .cnt_i(cnt_r),
                .duty_i(duty_i[8*g+7:8*g]),
                .pol_i(pol_all[g]),
                .oe_i(oe_all[g]),
                .dir_i(port_dir_i[g]),
                .latch_i(port_latch_i[g]),
                .pin_o(modulated_outputs_o[g]),
                .pin_oe_o(modulated_outputs_oe_o[g])
            );
        end
    endgenerate
endmodule // pop_top

// ==== core/pop_map.vh ====
`ifndef POP_MAP_VH
`define POP_MAP_VH
// register indices on the plain register port
`define POP_ADDR_W 3
`define POP_A_POL_LO 3'h0
`define POP_A_POL_HI 3'h1
`define POP_A_OE_LO 3'h2
`define POP_A_OE_HI 3'h3
`define POP_A_PCS 3'h4
`define POP_A_CCTL 3'h5
// reset values
`define POP_RST_8 8'h00
// peripheral clock select fields
`define POP_PCS_RSVD_HI 7
`define POP_PCS_RSVD_LO 6
`define POP_PCS_XB 5
`define POP_PCS_XA 4
`define POP_PCS_RSVD3 3
`define POP_PCS_CKB 2
`define POP_PCS_CKA 1
`define POP_PCS_XC 0
// counter clock control fields (own register)
`define POP_CC_EN 1
`define POP_CC_SRC 0
// channel slice counts
`define POP_CH_LO 8
// prescaler codes and divider masks
`define POP_PS_DIV2 2'h0
`define POP_PS_DIV4 2'h1
`define POP_PS_DIV8 2'h2
`define POP_PS_M2 4'h1
`define POP_PS_M4 4'h3
`define POP_PS_M8 4'h7
`define POP_PS_M16 4'hf
`define POP_DIV_STEP 4'h1
`define POP_CNT_STEP 8'h01
`define POP_RST_DIV 4'h0
// slot that carries an extra pulse, and basic pulse step
`define POP_SLOT_LAST 4'hf
`define POP_PULSE_STEP 4'h1
`endif

// ==== core/pop_chan.v ====
`include "pop_map.vh"
// one channel: pulse-division waveform, polarity and pin mode
module pop_chan (
    // clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // timing from the shared counter
    input wire tick_i,
    input wire [7:0] cnt_i,
    // configuration
    input wire [7:0] duty_i,
    input wire pol_i,
    input wire oe_i,
    input wire dir_i,
    input wire latch_i,
    // pin
    output reg pin_o,
    output reg pin_oe_o
);
    wire [3:0] slot = cnt_i[3:0];
    wire [3:0] pulse_no = cnt_i[7:4];
    // basic pulses rise at slot 0, so an extra pulse takes the last slot before that rise
    wire [3:0] pulse_nx = pulse_no + `POP_PULSE_STEP;
    wire [3:0] rev = {pulse_nx[0], pulse_nx[1], pulse_nx[2], pulse_nx[3]};
    wire add_here = (slot == `POP_SLOT_LAST) && ({1'b0, `POP_SLOT_LAST - rev} < {1'b0, duty_i[3:0]});
    // fixed rise at slot 0 lets an extra pulse at slot 15 merge into the next basic pulse
    wire basic_hi = (slot < duty_i[7:4]);
    wire wave = basic_hi | add_here;
    reg wave_r;
    // hold waveform between counter ticks so gated clocks do not glitch
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            wave_r <= 1'b0;
        end else if (tick_i) begin
            wave_r <= wave;
        end
    end
    // pin mode from direction and enable, polarity applied to pwm only
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            pin_oe_o <= dir_i;
            if (dir_i && oe_i) begin
                pin_o <= wave_r ^ pol_i;
            end else begin
                pin_o <= latch_i;
            end
        end
    end
endmodule // pop_chan

// ==== testbench/pop_monitor.sv ====
module pop_monitor #(
    parameter NCH = 16
) (
    // watched ports
    input wire clk_i,
    input wire sys_rst_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire [NCH-1:0] port_dir_i,
    input wire [NCH-1:0] port_latch_i,
    input wire [NCH-1:0] modulated_outputs_o,
    input wire [NCH-1:0] modulated_outputs_oe_o,
    input wire other_timer_clk_sel_a_o,
    input wire other_timer_clk_sel_b_o,
    input wire other_timer_clk_sel_c_o,
    input wire [7:0] count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] sh_r [8];
    wire [15:0] en = {sh_r[3], sh_r[2]};
    // shadow register file; bit 3 of index 4 never sticks
    always @(posedge clk_i)
        if (sys_rst_i)
            sh_r <= '{default: 8'h00};
        else if (wr_i && addr_i < 3'h6)
            sh_r[addr_i] <= (addr_i == 3'h4) ? (wdata_i & 8'hf7) : wdata_i;
    a_read_back: assert property (rd_i |=> rdata_o == $past(sh_r[addr_i])) else $error("bad read");
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("stray read data");
    a_pcs_rsvd: assert property (rd_i && addr_i == 3'h4 |=> !rdata_o[3]) else $error("bit 3 set");
    a_oe_dir: assert property (!$past(sys_rst_i) |-> modulated_outputs_oe_o == $past(port_dir_i))
        else $error("oe wrong");
    a_port_pin: assert property (!$past(sys_rst_i) |->
        ((modulated_outputs_o ^ $past(port_latch_i)) & ~$past(en & port_dir_i)) == '0)
        else $error("port pin wrong");
    a_cnt_stop: assert property (!sh_r[5][1] [*3] |-> $stable(count_o)) else $error("count moved");
    a_cnt_fast: assert property (sh_r[5][1:0] == 2'b10 [*4] |-> count_o == $past(count_o) + 8'h01)
        else $error("count not every cycle");
    a_cnt_slow: assert property (sh_r[5][1:0] == 2'b11 [*4] ##0 $changed(count_o) |=> $stable(count_o))
        else $error("divided count too fast");
    a_other_sel: assert property ($stable(sh_r[4]) |-> {other_timer_clk_sel_b_o, other_timer_clk_sel_a_o,
        other_timer_clk_sel_c_o} == {sh_r[4][5], sh_r[4][4], sh_r[4][0]}) else $error("select copy");
    // main scenarios reached
    c_read: cover property (rd_i ##1 rdata_o != 8'h00);
    c_slow: cover property (sh_r[5][1:0] == 2'b11 [*8]);
    c_pwm: cover property (|(en & port_dir_i & modulated_outputs_o));
endmodule // pop_monitor

// ==== testbench/pop_load.sv ====
module pop_load #(
    parameter NCH = 16
) (
    // clock and window control
    input wire clk_i,
    input wire clr_i,
    // pins
    input wire [NCH-1:0] pin_i,
    input wire [NCH-1:0] oe_i,
    // integrated high time
    output logic [8:0] hi_o [NCH]
);
    timeunit 1ns;
    timeprecision 1ps;
    // filter integrator; a released pin sinks to the pull-down
    always @(posedge clk_i)
        for (int n = 0; n < NCH; n++)
            hi_o[n] <= clr_i ? 9'h000 : hi_o[n] + {8'h00, pin_i[n] & oe_i[n]};
endmodule // pop_load

// ==== testbench/pop_top_bench.sv ====
module pop_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam NCH = 16;
    logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, clr_r = 1, sa, sb, sc;
    logic [2:0] addr_i = 0;
    logic [7:0] wdata_i = 0, rdata_o, count_o, v_r;
    logic [8*NCH-1:0] duty_i = 0;
    logic [NCH-1:0] port_dir_i = 0, port_latch_i = 0, pin, oe;
    logic [15:0] pol = 16'h300f;
    logic [8:0] hi [NCH];
    logic [7:0] wv [8] = '{8'ha5, 8'h5a, 8'hc3, 8'h3c, 8'h2d, 8'h00, 8'hff, 8'hff};
    logic [7:0] ev [8] = '{8'ha5, 8'h5a, 8'hc3, 8'h3c, 8'h25, 8'h00, 8'h00, 8'h00};
    int err_total = 0, total_checks = 0;
    always #20 clk_i = ~clk_i;
    pop_top #(.NCH(NCH)) u_dut (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .duty_i,
        .port_dir_i, .port_latch_i, .modulated_outputs_o(pin), .modulated_outputs_oe_o(oe),
        .other_timer_clk_sel_a_o(sa), .other_timer_clk_sel_b_o(sb), .other_timer_clk_sel_c_o(sc), .count_o);
    pop_load #(.NCH(NCH)) u_load (.clk_i, .clr_i(clr_r), .pin_i(pin), .oe_i(oe), .hi_o(hi));
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // strobe dropped a cycle later so back-to-back calls never clash
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1;
        wt(1);
        wr_i <= 0;
        wt(1);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1;
        wt(1);
        rd_i <= 0;
        #1 chk({1'b0, rdata_o}, {1'b0, e});
        wt(1);
    endtask
    // gap between two count steps, bounded
    task automatic per(input int e);
        int c;
        for (int i = 0; i < 2; i++) begin
            v_r = count_o;
            c = 0;
            while (count_o === v_r && c < 99) begin
                wt(1);
                c++;
            end
        end
        chk(9'(c), 9'(e));
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        wt(3);
        sys_rst_i <= 0;
        wt(1);
        for (int a = 0; a < 8; a++)
            rd(3'(a), 8'h00);
        for (int a = 0; a < 8; a++)
            wr(3'(a), wv[a]);
        for (int a = 0; a < 8; a++)
            rd(3'(a), ev[a]);
        chk({6'h00, sb, sa, sc}, 9'h005);
        // ch14 port output at full scale, latch loaded first; ch15 input
        for (int n = 0; n < NCH; n++)
            duty_i[8*n +: 8] <= 8'(n * 17);
        port_latch_i <= 16'h4000;
        port_dir_i <= 16'h7fff;
        wr(3'h0, pol[7:0]);
        wr(3'h1, pol[15:8]);
        wr(3'h2, 8'hff);
        wr(3'h3, 8'hbf);
        wr(3'h5, 8'h02);
        wt(20);
        clr_r <= 0;
        wt(256);
        clr_r <= 1;
        #1;
        for (int n = 0; n < NCH; n++)
            chk(hi[n], n == 15 ? 9'h0 : n == 14 ? 9'h100 : pol[n] ? 9'(256 - n * 17) : 9'(n * 17));
        chk({8'h00, oe[15]}, 9'h0);
        for (int k = 0; k < 4; k++) begin
            wr(3'h4, {5'h00, 2'(k), 1'b0});
            wr(3'h5, 8'h03);
            wt(40);
            per(2 << k);
        end
        wr(3'h5, 8'h00);
        wt(4);
        v_r = count_o;
        wt(30);
        chk({1'b0, count_o}, {1'b0, v_r});
        complete_run();
    end
endmodule // pop_top_bench
bind pop_top pop_monitor #(.NCH(NCH)) u_mon (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .port_dir_i, .port_latch_i, .modulated_outputs_o, .modulated_outputs_oe_o, .other_timer_clk_sel_a_o,
    .other_timer_clk_sel_b_o, .other_timer_clk_sel_c_o, .count_o);
